/* rtl/acr_config.sv */
// Purpose: register bank for trim, fault retry, routing and output crossbar
// Assumes: pwm_in is on mclk_in, fault input is asynchronous
// Notes: registers sit at four times their index on the bus
`timescale 1ns/1ps
`default_nettype none
module acr_config
    import acr_pkg::*;
#(
    parameter int unsigned CYC_PER_MS  = CLK_KHZ,
    parameter int unsigned TRIM_CYCLES = 16
) (
    // clock, reset, enable
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    // wishbone slave
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [31:0] wb_dat_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic        wb_we_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // power stage and channels
    input  wire logic        power_stage_fault_in,
    input  wire logic [3:0]  pwm_in,
    output logic      [3:0]  pwm_pins_out,
    output logic             stage_reset_out,
    // configuration
    output var acr_route_t   route_out,
    output logic             factory_trim_sel_out,
    output logic             trim_done_out,
    output logic             irq_out
);
    logic [3:0][1:0] xbar_r;
    logic [31:0]     rd_word;
    logic [31:0]     nw;
    logic [5:0]      idx;
    logic            wr_en;
    logic            fac_dis_r;
    logic            trim_busy_r;
    logic            trim_done_r;
    logic [15:0]     trim_cnt_r;
    logic [3:0]      fcode_r;
    logic            fwritten_r;
    logic [2:0]      sync_r;
    logic            fault_lvl_r;
    logic [31:0]     fcnt_r;
    acr_fault_st_t   fst_r;
    acr_fault_st_t   fst_nxt;
    logic [IRQ_W-1:0] irq_st_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_set;
    logic            f_ok;

    function automatic logic [31:0] wmerge(input logic [31:0] o,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] xbar_map(input logic [3:0]      p,
                                            input logic [3:0][1:0] x);
        logic [3:0] r;
        r = '0;
        for (int i = 0; i < 4; i++) begin
            r[i] = p[x[i]];
        end
        return r;
    endfunction

    function automatic logic src_ok(input logic [2:0] c);
        return (c == SRC_LEFT) || (c == SRC_RIGHT) || (c == SRC_ZERO);
    endfunction

    function automatic logic [31:0] period_cyc(input logic [3:0] c);
        logic [3:0] k;
        k = c - FAULT_MIN;
        if (k > FAULT_LAST) begin
            k = FAULT_LAST;
        end
        return 32'(PERIOD_MS[k]) * 32'(CYC_PER_MS);
    endfunction

    // register read mux
    assign idx = wb_adr_in[7:2];
    always_comb begin
        rd_word = '0;
        case (idx)
            IDX_TRIM: begin
                rd_word[TRIM_DONE_BIT] = trim_done_r;
                rd_word[TRIM_FAC_BIT]  = fac_dis_r;
            end
            IDX_FAULT: rd_word[3:0] = fcode_r;
            IDX_ROUTE: begin
                rd_word = ROUTE_RST;
                rd_word[CH1_MOD]      = route_out.ch1_mod;
                rd_word[CH1_SRC +: 3] = route_out.ch1_src;
                rd_word[CH2_MOD]      = route_out.ch2_mod;
                rd_word[CH2_SRC +: 3] = route_out.ch2_src;
            end
            IDX_CH4: begin
                rd_word = CH4_RST;
                rd_word[CH4_SRC +: 2] = route_out.ch4_src;
            end
            IDX_XBAR: begin
                rd_word = XBAR_RST;
                for (int i = 0; i < 4; i++) begin
                    rd_word[XBAR_LSB[i] +: 2] = xbar_r[i];
                end
            end
            IDX_IRQ_ST: rd_word[IRQ_W-1:0] = irq_st_r;
            IDX_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask_r;
            default: rd_word = '0;
        endcase
    end

    // writes commit at the edge where the master samples ack
    assign wr_en = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out;
    assign nw    = wmerge(rd_word, wb_dat_in, wb_sel_in);
    assign f_ok  = !fwritten_r && (nw[7:4] == 4'h0)
                   && (nw[3:0] >= FAULT_MIN);

    // bus handshake
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= '0;
        end else if (ce_in) begin
            wb_ack_out <= wb_cyc_in & wb_stb_in & !wb_ack_out;
            if (wb_cyc_in & wb_stb_in & !wb_ack_out) begin
                wb_dat_out <= wb_we_in ? 32'h0000_0000 : rd_word;
            end
        end
    end

    // oscillator trim
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            fac_dis_r   <= 1'b1;
            factory_trim_sel_out <= 1'b0;
            trim_busy_r <= 1'b0;
            trim_done_r <= 1'b0;
            trim_cnt_r  <= '0;
        end else if (ce_in) begin
            if (wr_en && idx == IDX_TRIM && wb_sel_in[0]) begin
                fac_dis_r   <= nw[TRIM_FAC_BIT];
                factory_trim_sel_out <= !nw[TRIM_FAC_BIT];
                trim_busy_r <= 1'b1;
                trim_done_r <= 1'b0;
                trim_cnt_r  <= 16'(TRIM_CYCLES);
            end else if (trim_busy_r) begin
                trim_cnt_r <= trim_cnt_r - 16'h0001;
                if (trim_cnt_r <= 16'h0001) begin
                    trim_busy_r <= 1'b0;
                    trim_done_r <= 1'b1;
                end
            end
        end
    end

    // fault period register, one accepted write per reset
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            fcode_r    <= FAULT_RST;
            fwritten_r <= 1'b0;
        end else if (ce_in) begin
            if (wr_en && idx == IDX_FAULT && wb_sel_in[0] && f_ok) begin
                fcode_r    <= nw[3:0];
                fwritten_r <= 1'b1;
            end
        end
    end

    // routing and channel 4 source
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            route_out.ch1_mod <= ROUTE_RST[CH1_MOD];
            route_out.ch1_src <= ROUTE_RST[CH1_SRC +: 3];
            route_out.ch2_mod <= ROUTE_RST[CH2_MOD];
            route_out.ch2_src <= ROUTE_RST[CH2_SRC +: 3];
            route_out.ch4_src <= CH4_RST[CH4_SRC +: 2];
        end else if (ce_in) begin
            if (wr_en && idx == IDX_ROUTE) begin
                route_out.ch1_mod <= nw[CH1_MOD];
                route_out.ch2_mod <= nw[CH2_MOD];
                if (src_ok(nw[CH1_SRC +: 3])) begin
                    route_out.ch1_src <= nw[CH1_SRC +: 3];
                end
                if (src_ok(nw[CH2_SRC +: 3])) begin
                    route_out.ch2_src <= nw[CH2_SRC +: 3];
                end
            end
            if (wr_en && idx == IDX_CH4) begin
                route_out.ch4_src <= nw[CH4_SRC +: 2];
            end
        end
    end

    // output crossbar selects
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            for (int i = 0; i < 4; i++) begin
                xbar_r[i] <= XBAR_RST[XBAR_LSB[i] +: 2];
            end
        end else if (ce_in) begin
            if (wr_en && idx == IDX_XBAR) begin
                for (int i = 0; i < 4; i++) begin
                    xbar_r[i] <= nw[XBAR_LSB[i] +: 2];
                end
            end
        end
    end

    // fault input synchroniser
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sync_r      <= '0;
            fault_lvl_r <= 1'b0;
        end else if (ce_in) begin
            sync_r <= {sync_r[1:0], power_stage_fault_in};
            if (sync_r[1] == sync_r[2]) begin
                fault_lvl_r <= sync_r[2];
            end
        end
    end

    // fault recovery sequence
    always_comb begin
        fst_nxt = fst_r;
        case (fst_r)
            F_RUN: begin
                if (fault_lvl_r) begin
                    fst_nxt = F_HALT;
                end
            end
            F_HALT: begin
                if (fcnt_r == 32'h0000_0000) begin
                    fst_nxt = F_RESTART;
                end
            end
            F_RESTART: fst_nxt = F_RUN;
            default: fst_nxt = F_RUN;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            fst_r           <= F_RUN;
            fcnt_r          <= '0;
            stage_reset_out <= 1'b0;
            pwm_pins_out    <= '0;
        end else if (ce_in) begin
            fst_r <= fst_nxt;
            if (fst_r == F_RUN) begin
                fcnt_r <= period_cyc(fcode_r);
            end else if (fcnt_r != 32'h0000_0000) begin
                fcnt_r <= fcnt_r - 32'h0000_0001;
            end
            stage_reset_out <= (fst_nxt == F_HALT);
            pwm_pins_out <= (fst_nxt == F_HALT) ? 4'h0
                            : xbar_map(pwm_in, xbar_r);
        end
    end

    // interrupt status, mask and output
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_TRIM]    = trim_busy_r && trim_cnt_r <= 16'h0001
                               && !(wr_en && idx == IDX_TRIM && wb_sel_in[0]);
        irq_set[IRQ_FAULT]   = (fst_r == F_RUN) && (fst_nxt == F_HALT);
        irq_set[IRQ_RESTART] = (fst_r == F_RESTART);
        irq_set[IRQ_REFUSED] = wr_en && idx == IDX_FAULT
                               && wb_sel_in[0] && !f_ok;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            irq_st_r   <= '0;
            irq_mask_r <= '0;
            irq_out    <= 1'b0;
        end else if (ce_in) begin
            if (wr_en && idx == IDX_IRQ_ST && wb_sel_in[0]) begin
                irq_st_r <= (irq_st_r & ~wb_dat_in[IRQ_W-1:0]) | irq_set;
            end else begin
                irq_st_r <= irq_st_r | irq_set;
            end
            if (wr_en && idx == IDX_IRQ_MASK && wb_sel_in[0]) begin
                irq_mask_r <= wb_dat_in[IRQ_W-1:0];
            end
            irq_out <= |(irq_st_r & irq_mask_r);
        end
    end

    assign trim_done_out        = trim_done_r;

    // checks
    default clocking cb @(posedge mclk_in iff ce_in); endclocking
    default disable iff (rst_in);

    property p_trim_zero;
        wr_en && idx == IDX_TRIM && wb_sel_in[0] && wb_dat_in[7:0] == 8'h00
        |=> !fac_dis_r ##0 !trim_done_r;
    endproperty
    a_trim_zero: assert property (p_trim_zero)
        else $error("zero trim write did not pick factory trim");

    property p_trim_read;
        wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out
        && idx == IDX_TRIM |=> wb_dat_out[TRIM_DONE_BIT] == $past(trim_done_r);
    endproperty
    a_trim_read: assert property (p_trim_read)
        else $error("trim done bit misreported");

    property p_halt_pins;
        fst_r == F_HALT |-> pwm_pins_out == 4'h0 && stage_reset_out;
    endproperty
    a_halt_pins: assert property (p_halt_pins)
        else $error("outputs active during fault halt");

    property p_restart;
        fst_r == F_HALT && fcnt_r == 32'h0000_0000
        |=> fst_r == F_RESTART ##1 fst_r == F_RUN && !stage_reset_out;
    endproperty
    a_restart: assert property (p_restart)
        else $error("no restart after retry period");

    property p_once;
        fwritten_r |=> $stable(fcode_r);
    endproperty
    a_once: assert property (p_once)
        else $error("fault period changed after first write");

    property p_reserved_period;
        wr_en && idx == IDX_FAULT && wb_dat_in[3:0] < FAULT_MIN
        |=> $stable(fcode_r) && irq_st_r[IRQ_REFUSED];
    endproperty
    a_reserved_period: assert property (p_reserved_period)
        else $error("reserved period code accepted");

    property p_src_reserved;
        wr_en && idx == IDX_ROUTE && !src_ok(nw[CH1_SRC +: 3])
        |=> $stable(route_out.ch1_src);
    endproperty
    a_src_reserved: assert property (p_src_reserved)
        else $error("reserved channel 1 source accepted");

    property p_xbar;
        !rst_in && fst_r == F_RUN && !fault_lvl_r
        |=> pwm_pins_out == xbar_map($past(pwm_in), $past(xbar_r));
    endproperty
    a_xbar: assert property (p_xbar)
        else $error("crossbar output mismatch");
endmodule
`default_nettype wire

/* rtl/acr_pkg.sv */
// Purpose: constants and types of the audio route, trim and fault block
// Assumes: 200 MHz mclk, classic Wishbone register access
// Notes on behaviour
// - writing zero to trim selects factory trim
// - trim done flag reads in bit six
// - factory trim bit resets one, zero selects
// - stage fault resets stage, halts all outputs
// - wait programmed period, then restart stage
// - period code table, default 299 ms
// - period written once, valid codes only
// - bits 23 and 19 pick modulation scheme
// - channel 1 source: left, right, zero
// - channel 2 source, same codes, right default
// - channel 4 source: half sum or left
// - any internal channel to any pin
// - crossbar fields at 20, 16, 12, 8
// - field value is channel number minus one
// - crossbar resets to 1, 3, 2, 4
package acr_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned CLK_KHZ = CLK_MHZ * 1000;

    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_TRIM     = 6'h1B;
    localparam logic [5:0] IDX_FAULT    = 6'h1C;
    localparam logic [5:0] IDX_ROUTE    = 6'h20;
    localparam logic [5:0] IDX_CH4      = 6'h21;
    localparam logic [5:0] IDX_XBAR     = 6'h25;
    localparam logic [5:0] IDX_IRQ_ST   = 6'h30;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h31;

    localparam int         TRIM_DONE_BIT = 6;
    localparam int         TRIM_FAC_BIT  = 1;
    localparam logic [3:0] FAULT_RST     = 4'h2;
    localparam logic [3:0] FAULT_MIN     = 4'h2;
    localparam logic [3:0] FAULT_LAST    = 4'h8;

    localparam logic [31:0] ROUTE_RST = 32'h0001_7772;
    localparam int          CH1_MOD   = 23;
    localparam int          CH1_SRC   = 20;
    localparam int          CH2_MOD   = 19;
    localparam int          CH2_SRC   = 16;
    localparam logic [2:0]  SRC_LEFT  = 3'h0;
    localparam logic [2:0]  SRC_RIGHT = 3'h1;
    localparam logic [2:0]  SRC_ZERO  = 3'h6;

    localparam logic [31:0] CH4_RST = 32'h0000_4303;
    localparam int          CH4_SRC = 8;

    localparam logic [31:0] XBAR_RST = 32'h0102_1345;
    localparam int          XBAR_LSB [4] = '{20, 16, 12, 8};

    localparam int IRQ_W       = 4;
    localparam int IRQ_TRIM    = 0;
    localparam int IRQ_FAULT   = 1;
    localparam int IRQ_RESTART = 2;
    localparam int IRQ_REFUSED = 3;

    // retry period in ms for codes 2 .. 10, then every higher code
    localparam logic [10:0] PERIOD_MS [9] = '{11'd299, 11'd449, 11'd598,
        11'd748, 11'd898, 11'd1047, 11'd1197, 11'd1346, 11'd1496};

    typedef struct packed {
        logic       ch1_mod;
        logic [2:0] ch1_src;
        logic       ch2_mod;
        logic [2:0] ch2_src;
        logic [1:0] ch4_src;
    } acr_route_t;

    typedef enum logic [1:0] {
        F_RUN     = 2'b00,
        F_HALT    = 2'b01,
        F_RESTART = 2'b10
    } acr_fault_st_t;
endpackage

/* test/acr_config_bench.sv */
// Purpose: self-checking bench of the config block
// Assumes: CYC_PER_MS 2 and TRIM_CYCLES 4 shorten the counts
// Notes: pins first, then register rows, pins again, trim, irq, fault retry
`timescale 1ns/1ps
`default_nettype none
module acr_config_bench import acr_pkg::*;;
    localparam int CPM = 2;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } acr_row_t;
    localparam acr_row_t ROWS [13] = '{
        '{1'b0, 8'h6C, 32'h0, 32'h2},
        '{1'b0, 8'h70, 32'h0, 32'h2},
        '{1'b0, 8'h80, 32'h0, 32'h17772},
        '{1'b0, 8'h84, 32'h0, 32'h4303},
        '{1'b0, 8'h94, 32'h0, 32'h1021345},
        '{1'b1, 8'h80, 32'hFFE60000, 32'hE67772},
        '{1'b1, 8'h80, 32'h230000, 32'h667772},
        '{1'b1, 8'h80, 32'h10000, 32'h17772},
        '{1'b1, 8'h84, 32'h100, 32'h4103},
        '{1'b1, 8'h84, 32'h0, 32'h4003},
        '{1'b1, 8'hFC, 32'h12345678, 32'h0},
        '{1'b1, 8'h70, 32'h35, 32'h2},
        '{1'b1, 8'h70, 32'h1, 32'h2}
    };
    localparam logic [3:0] CODES [3] = '{4'h9, 4'hB, 4'hE};
    localparam int         MS    [3] = '{1346, 1496, 1496};

    logic        mclk_in = 1'b0;
    logic        rst_in  = 1'b1;
    logic        fault   = 1'b0;
    logic        ce      = 1'b1;
    logic [3:0]  pwm     = 4'h0;
    logic        cyc, stb, we, ack, stg, irq, fsel, tdone;
    logic [7:0]  adr;
    logic [31:0] wd, rdat, q;
    logic [3:0]  sel, pins;
    acr_route_t  route;
    int          miscompares = 0;
    int          cmp_count   = 0;

    initial forever #2.5 mclk_in = ~mclk_in;

    acr_config #(.CYC_PER_MS(CPM), .TRIM_CYCLES(4)) dut (
        .mclk_in             (mclk_in),
        .rst_in              (rst_in),
        .ce_in               (ce),
        .wb_adr_in           (adr),
        .wb_dat_in           (wd),
        .wb_sel_in           (sel),
        .wb_we_in            (we),
        .wb_cyc_in           (cyc),
        .wb_stb_in           (stb),
        .wb_dat_out          (rdat),
        .wb_ack_out          (ack),
        .power_stage_fault_in(fault),
        .pwm_in              (pwm),
        .pwm_pins_out        (pins),
        .stage_reset_out     (stg),
        .route_out           (route),
        .factory_trim_sel_out(fsel),
        .trim_done_out       (tdone),
        .irq_out             (irq)
    );

    acr_host host (
        .mclk_in(mclk_in),
        .ack_in (ack),
        .dat_in (rdat),
        .cyc_out(cyc),
        .stb_out(stb),
        .we_out (we),
        .adr_out(adr),
        .dat_out(wd),
        .sel_out(sel)
    );

    task automatic test_done;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic hchk;
        if (host.tmo_cnt != 0) begin
            miscompares++;
            test_done();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
        hchk();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, q);
        hchk();
        chk("reg", e, q);
    endtask

    // waits on stage reset (s) or trim done, sampled at rising edges
    task automatic wait_hi(input logic s, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while ((s ? stg : tdone) !== 1'b1 && n < lim);
        if ((s ? stg : tdone) !== 1'b1) begin
            miscompares++;
            test_done();
        end
    endtask

    // field i of f names the channel on pin i
    task automatic pins_chk(input logic [7:0] f);
        logic [3:0] e;
        for (int v = 0; v < 16; v++) begin
            @(posedge mclk_in);
            pwm <= v[3:0];
            @(posedge mclk_in);
            @(negedge mclk_in);
            for (int i = 0; i < 4; i++) begin
                e[i] = v[f[2*i+:2]];
            end
            chk("pins", {28'h0, e}, {28'h0, pins});
        end
    endtask

    // counts the cycles stage reset stands after a fault pulse
    task automatic fault_run(input int ms);
        int n;
        n = 0;
        @(posedge mclk_in);
        pwm <= 4'hF;
        fault <= 1'b1;
        wait_hi(1'b1, 30);
        while (stg === 1'b1 && n < 4000) begin
            if (n == 8) fault <= 1'b0;
            if (n == 8) chk("halt pins", 32'h0, {28'h0, pins});
            n++;
            @(posedge mclk_in);
        end
        chk("halt cycles", ms * CPM + 1, n);
    endtask

    initial begin
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(negedge mclk_in);
        chk("flags", 32'h0, {28'h0, stg, irq, tdone, fsel});
        chk("route", 32'h7, {22'h0, route});
        pins_chk(8'hD8);
        foreach (ROWS[i]) begin
            if (ROWS[i].w) wr(ROWS[i].a, ROWS[i].d);
            rd(ROWS[i].a, ROWS[i].e);
        end
        chk("route", 32'h4, {22'h0, route});
        host.rmw(8'h94, 32'h333300, 32'h302100);
        hchk();
        pins_chk(8'h63);
        rd(8'h94, 32'h1302145);
        @(posedge mclk_in);
        ce  <= 1'b0;
        pwm <= 4'h0;
        repeat (3) @(posedge mclk_in);
        chk("frozen pins", 32'hF, {28'h0, pins});
        ce <= 1'b1;
        repeat (2) @(negedge mclk_in);
        chk("thawed pins", 32'h0, {28'h0, pins});
        for (int k = 0; k < 2; k++) begin
            host.trim(8'(2 * k));
            hchk();
            @(negedge mclk_in);
            chk("fsel", 32'(k == 0), {31'h0, fsel});
            chk("done", 32'h0, {31'h0, tdone});
            wait_hi(1'b0, 40);
            rd(8'h6C, 32'h40 | 32'(2 * k));
        end
        rd(8'hC0, 32'h9);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'hC4, 32'h8);
        repeat (2) @(negedge mclk_in);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'hC0, 32'h8);
        repeat (2) @(negedge mclk_in);
        chk("irq", 32'h0, {31'h0, irq});
        rd(8'hC0, 32'h1);
        wr(8'hC4, 32'h2);
        fault_run(299);
        rd(8'hC0, 32'h7);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'hC0, 32'hF);
        rd(8'hC0, 32'h0);
        foreach (CODES[i]) begin
            @(posedge mclk_in);
            rst_in <= 1'b1;
            repeat (3) @(posedge mclk_in);
            rst_in <= 1'b0;
            host.trim(8'h0);
            host.period(CODES[i]);
            hchk();
            rd(8'h70, {28'h0, CODES[i]});
            wr(8'h70, 32'h2);
            rd(8'h70, {28'h0, CODES[i]});
            fault_run(MS[i]);
        end
        test_done();
    end
endmodule
`default_nettype wire

/* test/acr_host.sv */
// Purpose: host model that programs the config block over wishbone
// Assumes: classic single cycles, one at a time
// Notes: tmo_cnt counts bus cycles that never saw ack
`timescale 1ns/1ps
`default_nettype none
module acr_host
    import acr_pkg::*;
(
    // clock
    input  wire logic        mclk_in,
    // wishbone master side
    input  wire logic        ack_in,
    input  wire logic [31:0] dat_in,
    output logic             cyc_out,
    output logic             stb_out,
    output logic             we_out,
    output logic      [7:0]  adr_out,
    output logic      [31:0] dat_out,
    output logic      [3:0]  sel_out
);
    int tmo_cnt = 0;

    initial begin
        cyc_out = 1'b0;
        stb_out = 1'b0;
        we_out  = 1'b0;
        adr_out = 8'h0;
        dat_out = 32'h0;
        sel_out = 4'hF;
    end

    // request held until ack is sampled, then released
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk_in);
        cyc_out <= 1'b1;
        stb_out <= 1'b1;
        we_out  <= w;
        adr_out <= a;
        dat_out <= d;
        do begin
            @(posedge mclk_in);
            n++;
        end while (ack_in !== 1'b1 && n < 64);
        q = dat_in;
        if (n >= 64) tmo_cnt++;
        cyc_out <= 1'b0;
        stb_out <= 1'b0;
        we_out  <= 1'b0;
    endtask

    // trim run after each reset, zero picks the factory value
    task automatic trim(input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, 8'h6C, {24'h0, d}, q);
    endtask

    // only the four code bits go out, once per reset
    task automatic period(input logic [3:0] c);
        logic [31:0] q;
        xfer(1'b1, 8'h70, {28'h0, c}, q);
    endtask

    // read-modify-write keeps reserved bits as read
    task automatic rmw(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] v);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        xfer(1'b1, a, (q & ~m) | v, q);
    endtask
endmodule
`default_nettype wire
